/* hw/bpa_pkg.sv */
// Purpose: Shared constants for the buffer pool admission and slope discard block.
// Assumes: One 100 MHz clock, APB register access, 32-bit data.
// Notes:   Offsets are byte addresses on the APB bus.
//
// Notes on behaviour
// - A pool with fewer than 64 free buffers counts as exhausted.
// - Check the port class pool first, then its class and root aggregate pools.
// - Grant only if all three pools are fine, then debit each by the buffer count.
// - On dequeue, return buffers and credit each associated pool.
// - Pool initialisation loads the counter with the configured pool size.
// - A pool size change adjusts the counter by the size difference, no reload.
// - Counters are signed; below 64 or negative the pool refuses all allocation.
// - Each queue holds a 10-bit policy index; each policy has high and low slopes.
// - The packet's congestion-priority flag selects the high or low slope.
// - A slope holds 14-bit start, 14-bit end and 8-bit inverse slope.
// - Inverse slope is unsigned 4.4 fixed point, fraction step 0.0625.
// - Discard uses instantaneous queue depth; no averaged occupancy is kept.
// - Depth at or above the end threshold discards the packet at once.
// - Random 0..127 times inverse slope plus start gives the random fill depth.
// - Depth at or above the random fill depth discards the packet.
// - A passing packet still drops if a pool is exhausted or free list empty.
// - Queue depth may reach high end threshold plus largest packet minus one.
// - The slope policy table holds 1,024 policies.
// - Each port class pool stores 5-bit class and root pointers into 32 pools.

package bpa_pkg;
  // Sizes of the pool and queue structures.
  localparam int NPC     = 80;    // Port class pools, one per queue.
  localparam int NAGG    = 32;    // Aggregate pools.
  localparam int NQ      = 80;    // Queues.
  localparam int NPOL    = 1024;  // Slope policies.
  localparam int PC_W    = 7;
  localparam int PTR_W   = 5;
  localparam int IDX_W   = 10;
  localparam int THR_W   = 14;
  localparam int INV_W   = 8;
  localparam int FRAC_W  = 4;
  localparam int RND_W   = 7;
  localparam int BUF_W   = 6;
  localparam int DEPTH_W = 16;
  localparam int CNT_W   = 22;
  localparam int FILL_W  = 20;
  localparam int LFSR_W  = 16;

  // Exhaustion guard band in buffers.
  localparam logic signed [CNT_W-1:0] GUARD_BUFS = 22'sh000040;

  // Reset values.
  localparam logic signed [CNT_W-1:0] CNT_RST   = 22'sh000000;
  localparam logic [CNT_W-1:0]        SIZE_RST  = 22'h000000;
  localparam logic [DEPTH_W-1:0]      DEPTH_RST = 16'h0000;
  localparam logic [LFSR_W-1:0]       LFSR_SEED = 16'hace1;

  // Register byte offsets.
  localparam logic [7:0] A_POOL_SEL  = 8'h00;
  localparam logic [7:0] A_POOL_INIT = 8'h04;
  localparam logic [7:0] A_POOL_SIZE = 8'h08;
  localparam logic [7:0] A_POOL_AVL  = 8'h0c;
  localparam logic [7:0] A_PC_PTRS   = 8'h10;
  localparam logic [7:0] A_Q_SEL     = 8'h14;
  localparam logic [7:0] A_Q_POLICY  = 8'h18;
  localparam logic [7:0] A_Q_DEPTH   = 8'h1c;
  localparam logic [7:0] A_SLP_SEL   = 8'h20;
  localparam logic [7:0] A_SLP_THR   = 8'h24;
  localparam logic [7:0] A_SLP_INV   = 8'h28;

  // Field positions.
  localparam int POOL_AGG_BIT = 7;   // POOL_SEL: set selects an aggregate pool.
  localparam int PTR_ROOT_LSB = 8;   // PC_PTRS: root pointer field.
  localparam int SLP_HI_BIT   = 16;  // SLP_SEL: set selects the high slope.
  localparam int THR_END_LSB  = 16;  // SLP_THR: end threshold field.
endpackage

/* hw/bpa_top.sv */
// Purpose: Buffer pool admission with guard band and per-queue two-slope discard.
// Assumes: Enqueue and dequeue requests come from logic on the same clock.
// Notes:   One decision per enqueue request, reported one cycle later.

`timescale 1ns/100ps

module bpa_top
  import bpa_pkg::*;
(
  input  wire logic             CLK_I,         // 100 MHz clock.
  input  wire logic             RSTN_I,        // Synchronous reset, active low.
  input  wire logic             PSEL_I,        // APB select.
  input  wire logic             PENABLE_I,     // APB enable.
  input  wire logic             PWRITE_I,      // APB direction.
  input  wire logic [7:0]       PADDR_I,       // APB byte address.
  input  wire logic [31:0]      PWDATA_I,      // APB write data.
  output logic      [31:0]      PRDATA_O,      // APB read data.
  output logic                  PREADY_O,      // APB ready.
  output logic                  PSLVERR_O,     // APB error on unmapped address.
  input  wire logic             ENQ_VALID_I,   // Packet asks to enter a queue.
  input  wire logic [PC_W-1:0]  ENQ_QUEUE_I,   // Target queue.
  input  wire logic             ENQ_HIPRIO_I,  // Congestion-priority flag.
  input  wire logic [BUF_W-1:0] ENQ_BUFS_I,    // Buffers the packet needs.
  input  wire logic             FREE_EMPTY_I,  // Global free list empty.
  input  wire logic             DEQ_VALID_I,   // Scheduler removed a packet.
  input  wire logic [PC_W-1:0]  DEQ_QUEUE_I,   // Queue it left.
  input  wire logic [BUF_W-1:0] DEQ_BUFS_I,    // Buffers it returns.
  output logic                  RES_VALID_O,   // Decision pulse.
  output logic                  RES_ADMIT_O,   // Packet admitted.
  output logic                  RES_DROP_SLP_O, // Dropped by slope check.
  output logic                  RES_DROP_POOL_O // Dropped by pools or free list.
);

  // ===========================================================================
  // State.
  // ===========================================================================
  logic signed [CNT_W-1:0] pc_cnt_q   [NPC];
  logic        [CNT_W-1:0] pc_size_q  [NPC];
  logic [PTR_W-1:0]        cls_ptr_q  [NPC];
  logic [PTR_W-1:0]        root_ptr_q [NPC];
  logic [IDX_W-1:0]        pol_q      [NQ];
  logic [DEPTH_W-1:0]      depth_q    [NQ];
  logic signed [CNT_W-1:0] agg_cnt_q  [NAGG];
  logic        [CNT_W-1:0] agg_size_q [NAGG];
  logic [THR_W-1:0]        slp_start_q[2*NPOL];
  logic [THR_W-1:0]        slp_end_q  [2*NPOL];
  logic [INV_W-1:0]        slp_inv_q  [2*NPOL];
  logic [7:0]              pool_sel_q;
  logic [PC_W-1:0]         q_sel_q;
  logic [IDX_W:0]          slp_sel_q;
  logic [LFSR_W-1:0]       lfsr_q;

  // ===========================================================================
  // APB decode.
  // ===========================================================================
  logic              apb_wr;
  logic              apb_setup;
  logic              addr_ok;
  logic              sel_agg;
  logic [PC_W-1:0]   sel_pc;
  logic [PTR_W-1:0]  sel_ag;
  logic              sel_pc_ok;
  logic              wr_init;
  logic              wr_size;
  logic [CNT_W-1:0]  wr_val;
  logic [31:0]       rd_d;

  // Zero wait states; writes act at the access edge.
  assign PREADY_O  = 1'b1;
  assign apb_wr    = PSEL_I && PENABLE_I && PWRITE_I;
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign addr_ok   = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= A_SLP_INV);
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
  assign sel_agg   = pool_sel_q[POOL_AGG_BIT];
  assign sel_pc    = pool_sel_q[PC_W-1:0];
  assign sel_ag    = pool_sel_q[PTR_W-1:0];
  assign sel_pc_ok = !sel_agg && (sel_pc < PC_W'(NPC));
  assign wr_init   = apb_wr && (PADDR_I == A_POOL_INIT);
  assign wr_size   = apb_wr && (PADDR_I == A_POOL_SIZE);
  assign wr_val    = PWDATA_I[CNT_W-1:0];

  // Select registers.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pool_sel_q <= 8'h00;
      q_sel_q    <= 7'h00;
      slp_sel_q  <= 11'h000;
    end else if (apb_wr) begin
      if (PADDR_I == A_POOL_SEL) pool_sel_q <= PWDATA_I[7:0];
      if (PADDR_I == A_Q_SEL)    q_sel_q    <= PWDATA_I[PC_W-1:0];
      if (PADDR_I == A_SLP_SEL)  slp_sel_q  <= {PWDATA_I[SLP_HI_BIT], PWDATA_I[IDX_W-1:0]};
    end
  end

  // Slope table writes; the table has no reset and software loads it.
  always_ff @(posedge CLK_I) begin
    if (apb_wr && (PADDR_I == A_SLP_THR)) begin
      slp_start_q[slp_sel_q] <= PWDATA_I[THR_W-1:0];
      slp_end_q[slp_sel_q]   <= PWDATA_I[THR_END_LSB +: THR_W];
    end
    if (apb_wr && (PADDR_I == A_SLP_INV)) begin
      slp_inv_q[slp_sel_q] <= PWDATA_I[INV_W-1:0];
    end
  end

  // Read data is latched in the setup cycle so it comes from a flip-flop.
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (PADDR_I)
      A_POOL_SEL:  rd_d = {24'h000000, pool_sel_q};
      A_POOL_SIZE: rd_d = sel_agg ? 32'(agg_size_q[sel_ag]) :
                          (sel_pc_ok ? 32'(pc_size_q[sel_pc]) : 32'h0000_0000);
      A_POOL_AVL:  rd_d = sel_agg ? 32'(agg_cnt_q[sel_ag]) :
                          (sel_pc_ok ? 32'(pc_cnt_q[sel_pc]) : 32'h0000_0000);
      A_PC_PTRS:   rd_d = sel_pc_ok ? {19'h00000, root_ptr_q[sel_pc], 3'h0, cls_ptr_q[sel_pc]}
                                    : 32'h0000_0000;
      A_Q_SEL:     rd_d = {25'h0000000, q_sel_q};
      A_Q_POLICY:  rd_d = (q_sel_q < PC_W'(NQ)) ? {22'h000000, pol_q[q_sel_q]} : 32'h0000_0000;
      A_Q_DEPTH:   rd_d = (q_sel_q < PC_W'(NQ)) ? {16'h0000, depth_q[q_sel_q]} : 32'h0000_0000;
      A_SLP_SEL:   rd_d = {15'h0000, slp_sel_q[IDX_W], 6'h00, slp_sel_q[IDX_W-1:0]};
      A_SLP_THR:   rd_d = {2'h0, slp_end_q[slp_sel_q], 2'h0, slp_start_q[slp_sel_q]};
      A_SLP_INV:   rd_d = {24'h000000, slp_inv_q[slp_sel_q]};
      default:     rd_d = 32'h0000_0000;
    endcase
  end

  // Read data register.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (apb_setup) begin
      PRDATA_O <= rd_d;
    end
  end

  // ===========================================================================
  // Pseudo-random source, advancing every cycle.
  // ===========================================================================
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[LFSR_W-2:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // ===========================================================================
  // Admission decision.
  // ===========================================================================
  logic                    q_ok;
  logic [IDX_W:0]          slp_idx;
  logic [THR_W-1:0]        e_start;
  logic [THR_W-1:0]        e_end;
  logic [INV_W-1:0]        e_inv;
  logic [DEPTH_W-1:0]      e_depth;
  logic [RND_W-1:0]        rnd;
  logic [FILL_W-1:0]       fill;
  logic [FILL_W-1:0]       depth_fx;
  logic [PTR_W-1:0]        e_cls;
  logic [PTR_W-1:0]        e_root;
  logic signed [CNT_W-1:0] e_pc_cnt;
  logic signed [CNT_W-1:0] e_cls_cnt;
  logic signed [CNT_W-1:0] e_root_cnt;
  logic                    drop_end;
  logic                    drop_fill;
  logic                    pools_ok;
  logic                    enq_admit;

  assign q_ok      = ENQ_QUEUE_I < PC_W'(NQ);
  assign slp_idx   = {ENQ_HIPRIO_I, q_ok ? pol_q[ENQ_QUEUE_I] : 10'h000};
  assign e_start   = slp_start_q[slp_idx];
  assign e_end     = slp_end_q[slp_idx];
  assign e_inv     = slp_inv_q[slp_idx];
  assign e_depth   = q_ok ? depth_q[ENQ_QUEUE_I] : DEPTH_RST;
  assign rnd       = lfsr_q[RND_W-1:0];
  // Fill depth kept with four fraction bits: start.0 plus rnd times inv.
  // Both factors are widened first so the 15-bit product is never cut to 8 bits.
  assign fill      = FILL_W'({e_start, 4'h0}) + FILL_W'(rnd) * FILL_W'(e_inv);
  assign depth_fx  = {e_depth, 4'h0};
  assign drop_end  = e_depth >= DEPTH_W'(e_end);
  assign drop_fill = depth_fx >= fill;
  assign e_cls     = q_ok ? cls_ptr_q[ENQ_QUEUE_I] : 5'h00;
  assign e_root    = q_ok ? root_ptr_q[ENQ_QUEUE_I] : 5'h00;
  assign e_pc_cnt  = q_ok ? pc_cnt_q[ENQ_QUEUE_I] : CNT_RST;
  assign e_cls_cnt = agg_cnt_q[e_cls];
  assign e_root_cnt = agg_cnt_q[e_root];
  // Port class pool first; aggregate pools only if it passes.
  assign pools_ok  = q_ok && (e_pc_cnt >= GUARD_BUFS) &&
                     (e_cls_cnt >= GUARD_BUFS) && (e_root_cnt >= GUARD_BUFS);
  assign enq_admit = ENQ_VALID_I && !drop_end && !drop_fill && pools_ok && !FREE_EMPTY_I;

  // Decision outputs, one cycle after the request.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      RES_VALID_O     <= 1'b0;
      RES_ADMIT_O     <= 1'b0;
      RES_DROP_SLP_O  <= 1'b0;
      RES_DROP_POOL_O <= 1'b0;
    end else begin
      RES_VALID_O     <= ENQ_VALID_I;
      RES_ADMIT_O     <= enq_admit;
      RES_DROP_SLP_O  <= ENQ_VALID_I && (drop_end || drop_fill);
      RES_DROP_POOL_O <= ENQ_VALID_I && !drop_end && !drop_fill &&
                         (!pools_ok || FREE_EMPTY_I);
    end
  end

  // ===========================================================================
  // Counters: debits, credits, initialisation and resizing per pool and queue.
  // ===========================================================================
  logic signed [CNT_W-1:0] enq_amt;
  logic signed [CNT_W-1:0] deq_amt;
  logic [PTR_W-1:0]        d_cls;
  logic [PTR_W-1:0]        d_root;

  assign enq_amt = CNT_W'(ENQ_BUFS_I);
  assign deq_amt = CNT_W'(DEQ_BUFS_I);
  assign d_cls   = (DEQ_QUEUE_I < PC_W'(NPC)) ? cls_ptr_q[DEQ_QUEUE_I] : 5'h00;
  assign d_root  = (DEQ_QUEUE_I < PC_W'(NPC)) ? root_ptr_q[DEQ_QUEUE_I] : 5'h00;

  for (genvar g = 0; g < NPC; g++) begin : g_pc
    logic signed [CNT_W-1:0] delta;
    logic                    hit_enq;
    logic                    hit_deq;
    logic                    hit_sw;

    assign hit_enq = enq_admit && (ENQ_QUEUE_I == PC_W'(g));
    assign hit_deq = DEQ_VALID_I && (DEQ_QUEUE_I == PC_W'(g));
    assign hit_sw  = !sel_agg && (sel_pc == PC_W'(g));

    // Enqueue, dequeue and resize contributions of one cycle add up; an init write in that cycle overrides them.
    always_comb begin
      delta = CNT_RST;
      if (hit_enq) delta = delta - enq_amt;
      if (hit_deq) delta = delta + deq_amt;
      if (wr_size && hit_sw) delta = delta + $signed(wr_val - pc_size_q[g]);
    end

    // Port class counter and its configured size.
    always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
        pc_cnt_q[g]  <= CNT_RST;
        pc_size_q[g] <= SIZE_RST;
      end else if (wr_init && hit_sw) begin
        pc_cnt_q[g]  <= $signed(wr_val);
        pc_size_q[g] <= wr_val;
      end else begin
        pc_cnt_q[g]  <= pc_cnt_q[g] + delta;
        if (wr_size && hit_sw) pc_size_q[g] <= wr_val;
      end
    end

    // Pointers and policy index, plus the queue's live depth.
    always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
        cls_ptr_q[g]  <= 5'h00;
        root_ptr_q[g] <= 5'h00;
        pol_q[g]      <= 10'h000;
        depth_q[g]    <= DEPTH_RST;
      end else begin
        if (apb_wr && (PADDR_I == A_PC_PTRS) && hit_sw) begin
          cls_ptr_q[g]  <= PWDATA_I[PTR_W-1:0];
          root_ptr_q[g] <= PWDATA_I[PTR_ROOT_LSB +: PTR_W];
        end
        if (apb_wr && (PADDR_I == A_Q_POLICY) && (q_sel_q == PC_W'(g))) begin
          pol_q[g] <= PWDATA_I[IDX_W-1:0];
        end
        // Depth is 16 bits, wide enough for end threshold plus 63.
        depth_q[g] <= depth_q[g] + (hit_enq ? DEPTH_W'(ENQ_BUFS_I) : DEPTH_RST)
                                 - (hit_deq ? DEPTH_W'(DEQ_BUFS_I) : DEPTH_RST);
      end
    end
  end

  for (genvar a = 0; a < NAGG; a++) begin : g_agg
    logic signed [CNT_W-1:0] delta;
    logic                    hit_sw;

    assign hit_sw = sel_agg && (sel_ag == PTR_W'(a));

    // Class and root pointers each count, as both pools are charged.
    always_comb begin
      delta = CNT_RST;
      if (enq_admit && (e_cls == PTR_W'(a)))  delta = delta - enq_amt;
      if (enq_admit && (e_root == PTR_W'(a))) delta = delta - enq_amt;
      if (DEQ_VALID_I && (d_cls == PTR_W'(a)))  delta = delta + deq_amt;
      if (DEQ_VALID_I && (d_root == PTR_W'(a))) delta = delta + deq_amt;
      if (wr_size && hit_sw) delta = delta + $signed(wr_val - agg_size_q[a]);
    end

    // Aggregate counter and its configured size.
    always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
        agg_cnt_q[a]  <= CNT_RST;
        agg_size_q[a] <= SIZE_RST;
      end else if (wr_init && hit_sw) begin
        agg_cnt_q[a]  <= $signed(wr_val);
        agg_size_q[a] <= wr_val;
      end else begin
        agg_cnt_q[a]  <= agg_cnt_q[a] + delta;
        if (wr_size && hit_sw) agg_size_q[a] <= wr_val;
      end
    end
  end

  // ===========================================================================
  // Assertions and covers.
  // ===========================================================================
  logic quiet_pc;

  // No other change touches the enqueue pool this cycle.
  assign quiet_pc = !DEQ_VALID_I && !wr_init && !wr_size;

  pool_guard_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    RES_ADMIT_O |-> $past(e_pc_cnt) >= GUARD_BUFS)
    else $error("admitted from a port class pool under the guard band");

  agg_guard_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    RES_ADMIT_O |-> ($past(e_cls_cnt) >= GUARD_BUFS) && ($past(e_root_cnt) >= GUARD_BUFS))
    else $error("admitted from an aggregate pool under the guard band");

  end_drop_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ENQ_VALID_I && drop_end |=> RES_DROP_SLP_O && !RES_ADMIT_O)
    else $error("depth at end threshold was not discarded");

  fill_drop_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    RES_ADMIT_O |-> $past(depth_fx) < $past(fill))
    else $error("admitted at or above the random fill depth");

  free_empty_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ENQ_VALID_I && FREE_EMPTY_I |=> !RES_ADMIT_O && RES_VALID_O)
    else $error("admitted with an empty free list");

  debit_pc_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    enq_admit && quiet_pc |=>
      pc_cnt_q[$past(ENQ_QUEUE_I)] == $past(e_pc_cnt) - CNT_W'($past(ENQ_BUFS_I)))
    else $error("port class pool not debited by the granted count");

  credit_pc_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    DEQ_VALID_I && !ENQ_VALID_I && !wr_init && !wr_size && (DEQ_QUEUE_I < PC_W'(NPC)) |=>
      pc_cnt_q[$past(DEQ_QUEUE_I)] ==
        $past(pc_cnt_q[DEQ_QUEUE_I]) + CNT_W'($past(DEQ_BUFS_I)))
    else $error("port class pool not credited on dequeue");

  resize_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr_size && sel_pc_ok && !ENQ_VALID_I && !DEQ_VALID_I |=>
      pc_cnt_q[$past(sel_pc)] == $past(pc_cnt_q[sel_pc]) + $signed($past(wr_val - pc_size_q[sel_pc])))
    else $error("pool resize did not adjust by the difference");

  init_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr_init && sel_pc_ok |=> pc_cnt_q[$past(sel_pc)] == $signed($past(wr_val)))
    else $error("pool initialisation did not load the size");

  onehot_res_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    RES_VALID_O |-> $onehot({RES_ADMIT_O, RES_DROP_SLP_O, RES_DROP_POOL_O}))
    else $error("decision did not carry exactly one result");

  idle_res_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !RES_VALID_O |-> !RES_ADMIT_O && !RES_DROP_SLP_O && !RES_DROP_POOL_O)
    else $error("result bit raised without a decision");

  depth_up_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    enq_admit && !DEQ_VALID_I |=> depth_q[$past(ENQ_QUEUE_I)] == $past(e_depth) + DEPTH_W'($past(ENQ_BUFS_I)))
    else $error("queue depth did not grow by the admitted count");

  neg_block_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ENQ_VALID_I && q_ok && (e_pc_cnt < CNT_RST) |=> !RES_ADMIT_O)
    else $error("admitted from a negative port class pool");

  admit_c: cover property (@(posedge CLK_I) disable iff (!RSTN_I) RES_ADMIT_O);
  slope_c: cover property (@(posedge CLK_I) disable iff (!RSTN_I) RES_VALID_O && RES_DROP_SLP_O);
  pool_c:  cover property (@(posedge CLK_I) disable iff (!RSTN_I) RES_VALID_O && RES_DROP_POOL_O);
  neg_c:   cover property (@(posedge CLK_I) disable iff (!RSTN_I) pc_cnt_q[0] < CNT_RST);
  fill_c:  cover property (@(posedge CLK_I) disable iff (!RSTN_I) ENQ_VALID_I && drop_fill && !drop_end);

endmodule

/* sim/bpa_src.sv */
// Purpose: Packet source and queue scheduler model facing the admission block.
// Assumes: Same clock as the block; the testbench calls the tasks.
// Notes:   Data lines show the inverse of the last value while idle.
`timescale 1ns/100ps

module bpa_src
  import bpa_pkg::*;
(
  input  wire logic        clk_i,    // Clock.
  output logic             enq_v_o,  // Enqueue request.
  output logic [PC_W-1:0]  enq_q_o,  // Target queue.
  output logic             enq_hi_o, // Priority flag.
  output logic [BUF_W-1:0] enq_b_o,  // Buffers needed.
  output logic             deq_v_o,  // Dequeue event.
  output logic [PC_W-1:0]  deq_q_o,  // Queue left.
  output logic [BUF_W-1:0] deq_b_o   // Buffers returned.
);
  // ==========================================================
  // Idle values, then one-cycle request pulses.
  initial begin
    {enq_v_o, enq_q_o, enq_hi_o, enq_b_o} = '0;
    {deq_v_o, deq_q_o, deq_b_o} = '0;
  end

  // One packet; the port width keeps every packet below 64 buffers.
  task automatic enq(input logic [PC_W-1:0] q, input logic hi, input logic [BUF_W-1:0] b);
    @(posedge clk_i);
    {enq_v_o, enq_q_o, enq_hi_o, enq_b_o} <= {1'b1, q, hi, b};
    @(posedge clk_i);
    {enq_v_o, enq_q_o, enq_hi_o, enq_b_o} <= {1'b0, ~q, ~hi, ~b};
  endtask

  // One packet scheduled out of a queue.
  task automatic deq(input logic [PC_W-1:0] q, input logic [BUF_W-1:0] b);
    @(posedge clk_i);
    {deq_v_o, deq_q_o, deq_b_o} <= {1'b1, q, b};
    @(posedge clk_i);
    {deq_v_o, deq_q_o, deq_b_o} <= {1'b0, ~q, ~b};
  endtask
endmodule

/* sim/tb_buffer_pool_admission_red_drop.sv */
// Purpose: Self-checking bench for pool admission and slope discard.
// Assumes: Zero-wait APB slave; decision one cycle after each request.
// Notes:   Slope thresholds are written as ready buffer counts.
`timescale 1ns/100ps

module tb_buffer_pool_admission_red_drop
  import bpa_pkg::*;
;
  // ==========================================================
  // Signals, counters and the clock.
  logic             clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, fe = 0, err;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h00000000, prdata, rd;
  logic             pready, pslverr, ev, eh, dv, rv, ra, rs, rp;
  logic [PC_W-1:0]  eq, dq;
  logic [BUF_W-1:0] eb, db;
  logic [31:0]      sel [3] = '{32'h00000000, 32'h00000081, 32'h00000082};
  int               n_fail = 0, comparisons = 0, cyc = 0;
  initial forever #5 clk = ~clk;

  bpa_top dut_u (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .ENQ_VALID_I(ev), .ENQ_QUEUE_I(eq), .ENQ_HIPRIO_I(eh), .ENQ_BUFS_I(eb), .FREE_EMPTY_I(fe),
    .DEQ_VALID_I(dv), .DEQ_QUEUE_I(dq), .DEQ_BUFS_I(db), .RES_VALID_O(rv), .RES_ADMIT_O(ra),
    .RES_DROP_SLP_O(rs), .RES_DROP_POOL_O(rp));
  bpa_src src_u (.clk_i(clk), .enq_v_o(ev), .enq_q_o(eq), .enq_hi_o(eh), .enq_b_o(eb),
    .deq_v_o(dv), .deq_q_o(dq), .deq_b_o(db));

  // ==========================================================
  // Bus, compare and report tasks.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    {psel, pen} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    check(what, exp, rd);
  endtask
  task automatic pools(input logic [31:0] exp);
    for (int i = 0; i < 3; i++) begin
      wr(A_POOL_SEL, sel[i]);
      rdchk(A_POOL_AVL, exp, "pool avail");
    end
  endtask
  task automatic slope(input logic hi, input logic [13:0] s, input logic [13:0] e, input logic [7:0] v);
    wr(A_SLP_SEL, {15'h0000, hi, 16'h03ff});
    wr(A_SLP_THR, {2'h0, e, 2'h0, s});
    wr(A_SLP_INV, {24'h000000, v});
  endtask
  task automatic enq(input logic hi, input logic [BUF_W-1:0] b, input logic [2:0] exp, input string what);
    src_u.enq(7'h00, hi, b);
    #1;
    check(what, {28'h0000000, 1'b1, exp}, {28'h0000000, rv, ra, rs, rp});
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 1000 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      test_done;
    end
  end

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdchk(A_Q_DEPTH, 32'h00000000, "depth reset");
    for (int i = 0; i < 3; i++) begin
      wr(A_POOL_SEL, sel[i]);
      wr(A_POOL_INIT, 32'h000000c8);
    end
    pools(32'h000000c8);
    wr(A_POOL_SEL, 32'h00000000);
    wr(A_PC_PTRS, 32'h00000201);
    wr(A_Q_SEL, 32'h00000000);
    wr(A_Q_POLICY, 32'h000003ff);
    slope(1'b0, 14'd1000, 14'd2000, 8'h10);
    slope(1'b1, 14'd1000, 14'd10, 8'h00);
    enq(1'b0, 6'd10, 3'b100, "admit");
    pools(32'h000000be);
    rdchk(A_Q_DEPTH, 32'h0000000a, "depth");
    enq(1'b1, 6'd1, 3'b010, "end drop");
    slope(1'b1, 14'd5, 14'd100, 8'h00);
    enq(1'b1, 6'd1, 3'b010, "fill drop");
    @(posedge clk);
    fe <= 1'b1;
    enq(1'b0, 6'd1, 3'b001, "free empty");
    @(posedge clk);
    fe <= 1'b0;
    wr(A_POOL_SEL, 32'h00000000);
    wr(A_POOL_SIZE, 32'h00000049);
    rdchk(A_POOL_AVL, 32'h0000003f, "resize");
    enq(1'b0, 6'd1, 3'b001, "guard band");
    src_u.deq(7'h00, 6'd1);
    rdchk(A_POOL_AVL, 32'h00000040, "return");
    enq(1'b0, 6'd1, 3'b100, "guard lifted");
    wr(A_POOL_SIZE, 32'h00000000);
    rdchk(A_POOL_AVL, 32'hfffffff6, "negative");
    slope(1'b0, 14'd2, 14'd2000, 8'h01);
    enq(1'b0, 6'd1, 3'b010, "fraction drop");
    apb(1'b0, 8'h40, 32'h00000000);
    check("unmapped", 32'h00000001, {31'h00000000, err});
    test_done;
  end
endmodule
